// [logic/acb_clk_div.sv]
// sampling clock divider, gives a one-cycle enable per divided period
`timescale 1ns/10ps
module acb_clk_div
	import acb_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       nrst,
	input  wire logic [1:0] divSel,
	output logic            sampleEn
);

	logic [1:0] cnt_ff;
	logic [1:0] lastCnt;

	// =====================================================================
	always_comb begin
		case (divSel)
			DIV_BY2: lastCnt = DIV_CNT_2;
			DIV_BY4: lastCnt = DIV_CNT_4;
			default: lastCnt = DIV_CNT_1;
		endcase
	end

	assign sampleEn = (cnt_ff >= lastCnt);

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cnt_ff <= '0;
		end else if (sampleEn) begin
			cnt_ff <= '0;
		end else begin
			cnt_ff <= cnt_ff + 2'h1;
		end
	end

	// =====================================================================
	divide_by4_a: assert property (@(posedge clk) disable iff (!nrst)
		(divSel == DIV_BY4) && sampleEn ##1 (divSel == DIV_BY4) [*4]
		|-> sampleEn)
		else $error("divide by four gap wrong");

	divide_gap_a: assert property (@(posedge clk) disable iff (!nrst)
		(divSel == DIV_BY4) && sampleEn ##1 (divSel == DIV_BY4) [*3]
		|-> $past(sampleEn, 1) == 1'b0 && $past(sampleEn, 2) == 1'b0)
		else $error("enable too early at divide by four");

	divide_two_a: assert property (@(posedge clk) disable iff (!nrst)
		(divSel == DIV_BY2) && sampleEn ##1 (divSel == DIV_BY2) [*2]
		|-> sampleEn && !$past(sampleEn))
		else $error("divide by two not alternating");

endmodule : acb_clk_div

// [logic/acb_config_bank.sv]
// configuration register bank of a dual channel converter
// Behaviour
// - custom word bits 13..6 stored in bits 7..0 of the high register
// - custom word bits 5..0 stored in bits 7..2 of the low register
// - channel with custom-pattern select outputs the custom word instead of samples
// - power bit 6 powers down channel A
// - power bit 5 powers down channel B
// - power bit 3 places both converters in standby
// - power bit 2 puts the whole device in global power-down
// - role bit 0 clear: high sleep pin forces global power-down
// - role bit 0 set: high sleep pin forces standby
// - eight-bit swing code drives data lanes, bit and frame clocks
// - clock bits 7..6 select divide by one, one, two or four
`timescale 1ns/10ps
module acb_config_bank
	import acb_pkg::*;
(
	input  wire logic                              clk,
	input  wire logic                              nrst,
	input  wire logic [ADDR_W-1:0]                 avs_address,
	input  wire logic                              avs_read,
	input  wire logic                              avs_write,
	input  wire logic [3:0]                        avs_byteenable,
	input  wire logic [31:0]                       avs_writedata,
	output logic      [31:0]                       avs_readdata,
	output logic                                   avs_waitrequest,
	input  wire logic                              sleepPin,
	input  wire logic [CHANNELS-1:0][3:0]          chanPatternSelect,
	input  wire logic [CHANNELS-1:0][WORD_W-1:0]   chanSample,
	output logic      [CHANNELS-1:0][WORD_W-1:0]   chanData,
	output acb_power_t                             power,
	output logic      [1:0]                        slowRateSelect,
	output logic      [7:0]                        swingCode,
	output logic                                   swingCodeLegal,
	output logic      [1:0]                        clkDivSelect,
	output logic                                   sampleEn
);

	// =====================================================================
	// bus request and decode
	acb_avs_req_t req;
	logic         ack_ff;
	logic         accept;
	logic [7:0]   regIdx;
	logic         idxOk;
	logic [7:0]   rdByte;
	logic         wrLow;

	assign req.address    = avs_address;
	assign req.read       = avs_read;
	assign req.write      = avs_write;
	assign req.byteenable = avs_byteenable;
	assign req.writedata  = avs_writedata;

	assign regIdx = req.address[ADDR_W-1:ADDR_LSB];
	assign idxOk  = (req.address[ADDR_LSB-1:0] == '0);

	// one wait state, the request completes at the second edge
	assign avs_waitrequest = (req.read || req.write) && !ack_ff;
	assign accept          = (req.read || req.write) && ack_ff;
	assign wrLow           = req.write && accept && req.byteenable[0] && idxOk;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ack_ff <= 1'b0;
		end else begin
			ack_ff <= (req.read || req.write) && !ack_ff;
		end
	end

	// =====================================================================
	// register storage
	logic [7:0] customHigh_ff;
	logic [7:0] customLow_ff;
	logic [7:0] slowRate_ff;
	logic [7:0] powerCtl_ff;
	logic [7:0] swing_ff;
	logic [7:0] clkDiv_ff;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			customHigh_ff <= REG_RESET;
			customLow_ff  <= REG_RESET;
			slowRate_ff   <= REG_RESET;
			powerCtl_ff   <= REG_RESET;
			swing_ff      <= REG_RESET;
			clkDiv_ff     <= REG_RESET;
		end else if (wrLow) begin
			case (regIdx)
				IDX_CUSTOM_HIGH: customHigh_ff <= req.writedata[7:0] & MASK_CUSTOM_HIGH;
				IDX_CUSTOM_LOW:  customLow_ff  <= req.writedata[7:0] & MASK_CUSTOM_LOW;
				IDX_SLOW_RATE:   slowRate_ff   <= req.writedata[7:0] & MASK_SLOW_RATE;
				IDX_POWER:       powerCtl_ff   <= req.writedata[7:0] & MASK_POWER;
				IDX_SWING:       swing_ff      <= req.writedata[7:0] & MASK_SWING;
				IDX_CLK_DIV:     clkDiv_ff     <= req.writedata[7:0] & MASK_CLK_DIV;
				default: begin
				end
			endcase
		end
	end

	// =====================================================================
	// read path, unmapped or misaligned reads return zero
	always_comb begin
		case (regIdx)
			IDX_CUSTOM_HIGH: rdByte = customHigh_ff;
			IDX_CUSTOM_LOW:  rdByte = customLow_ff;
			IDX_SLOW_RATE:   rdByte = slowRate_ff;
			IDX_POWER:       rdByte = powerCtl_ff;
			IDX_SWING:       rdByte = swing_ff;
			IDX_CLK_DIV:     rdByte = clkDiv_ff;
			default:         rdByte = 8'h00;
		endcase
		if (!idxOk) begin
			rdByte = 8'h00;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			avs_readdata <= 32'h0000_0000;
		end else if (req.read && !ack_ff) begin
			avs_readdata <= {24'h00_0000, rdByte};
		end
	end

	// =====================================================================
	// power control and sleep pin
	logic        sleepSync;
	logic [13:0] customWord;

	acb_sync2 #(
		.WIDTH (1)
	) u_sleep_sync (
		.clk     (clk),
		.nrst    (nrst),
		.asyncIn (sleepPin),
		.syncOut (sleepSync)
	);

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			power <= '0;
		end else begin
			power.fullChipOff <= powerCtl_ff[POS_FULL_OFF]
				|| (sleepSync && !powerCtl_ff[POS_SLEEP_ROLE]);
			power.standby     <= powerCtl_ff[POS_STANDBY]
				|| (sleepSync && powerCtl_ff[POS_SLEEP_ROLE]);
			power.chanAOff    <= powerCtl_ff[POS_CHAN_A_OFF];
			power.chanBOff    <= powerCtl_ff[POS_CHAN_B_OFF];
		end
	end

	// =====================================================================
	// plain field outputs
	assign slowRateSelect = slowRate_ff[1:0];
	assign swingCode      = swing_ff;
	assign clkDivSelect   = clkDiv_ff[POS_CLK_DIV+:2];
	assign customWord     = {customHigh_ff, customLow_ff[POS_CUSTOM_LOW+:6]};

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			swingCodeLegal <= 1'b1;
		end else begin
			swingCodeLegal <= (swing_ff == SWING_DEFAULT) || (swing_ff == SWING_LESS_50)
				|| (swing_ff == SWING_LESS_100) || (swing_ff == SWING_LESS_300)
				|| (swing_ff == SWING_MORE_100);
		end
	end

	acb_clk_div u_clk_div (
		.clk      (clk),
		.nrst     (nrst),
		.divSel   (clkDivSelect),
		.sampleEn (sampleEn)
	);

	// =====================================================================
	// per channel output select
	genvar ch;
	generate
		for (ch = 0; ch < CHANNELS; ch++) begin : g_chan
			always_ff @(posedge clk or negedge nrst) begin
				if (!nrst) begin
					chanData[ch] <= '0;
				end else if (chanPatternSelect[ch] == PATTERN_CUSTOM) begin
					chanData[ch] <= customWord;
				end else begin
					chanData[ch] <= chanSample[ch];
				end
			end

			custom_out_a: assert property (@(posedge clk) disable iff (!nrst)
				chanPatternSelect[ch] == PATTERN_CUSTOM
				|=> chanData[ch] == {$past(customHigh_ff), $past(customLow_ff[7:2])})
				else $error("custom word not driven on channel");

			sample_pass_a: assert property (@(posedge clk) disable iff (!nrst)
				chanPatternSelect[ch] != PATTERN_CUSTOM |=> chanData[ch] == $past(chanSample[ch]))
				else $error("sample not passed on channel");
		end
	endgenerate

	// =====================================================================
	// checks
	write_high_a: assert property (@(posedge clk) disable iff (!nrst)
		wrLow && regIdx == IDX_CUSTOM_HIGH |=> customWord[13:6] == $past(req.writedata[7:0]))
		else $error("custom high bits not stored");

	write_low_a: assert property (@(posedge clk) disable iff (!nrst)
		wrLow && regIdx == IDX_CUSTOM_LOW
		|=> customWord[5:0] == $past(req.writedata[7:2]) && customLow_ff[1:0] == 2'h0)
		else $error("custom low bits not stored");

	readback_a: assert property (@(posedge clk) disable iff (!nrst)
		avs_read && !ack_ff && idxOk && regIdx == IDX_SWING
		|=> avs_readdata[7:0] == $past(swingCode) && avs_readdata[31:8] == 24'h00_0000)
		else $error("swing readback differs");

	wait_one_a: assert property (@(posedge clk) disable iff (!nrst)
		(avs_read || avs_write) && !ack_ff ##1 $stable(req)
		|-> !avs_waitrequest)
		else $error("request not answered after one wait");

	chan_a_off_a: assert property (@(posedge clk) disable iff (!nrst)
		powerCtl_ff[POS_CHAN_A_OFF] ##1 powerCtl_ff[POS_CHAN_A_OFF] |-> power.chanAOff)
		else $error("channel A not powered down");

	chan_b_off_a: assert property (@(posedge clk) disable iff (!nrst)
		##1 power.chanBOff == $past(powerCtl_ff[POS_CHAN_B_OFF]))
		else $error("channel B power state wrong");

	standby_a: assert property (@(posedge clk) disable iff (!nrst)
		powerCtl_ff[POS_STANDBY] |=> power.standby)
		else $error("standby bit ignored");

	global_off_a: assert property (@(posedge clk) disable iff (!nrst)
		powerCtl_ff[POS_FULL_OFF] |=> power.fullChipOff)
		else $error("global power-down bit ignored");

	pin_global_a: assert property (@(posedge clk) disable iff (!nrst)
		sleepPin ##2 !powerCtl_ff[POS_SLEEP_ROLE] |=> power.fullChipOff)
		else $error("sleep pin did not force global power-down");

	pin_standby_a: assert property (@(posedge clk) disable iff (!nrst)
		sleepSync && powerCtl_ff[POS_SLEEP_ROLE] && !powerCtl_ff[POS_FULL_OFF]
		|=> power.standby && !power.fullChipOff)
		else $error("sleep pin did not force standby");

	write_swing_a: assert property (@(posedge clk) disable iff (!nrst)
		wrLow && regIdx == IDX_SWING |=> swingCode == $past(req.writedata[7:0]))
		else $error("swing code not stored");

	write_clkdiv_a: assert property (@(posedge clk) disable iff (!nrst)
		wrLow && regIdx == IDX_CLK_DIV |=> clkDivSelect == $past(req.writedata[POS_CLK_DIV+:2]))
		else $error("divider select not stored");

	write_slow_a: assert property (@(posedge clk) disable iff (!nrst)
		wrLow && regIdx == IDX_SLOW_RATE |=> slowRateSelect == $past(req.writedata[1:0]))
		else $error("slow rate select not stored");

	reserved_zero_a: assert property (@(posedge clk) disable iff (!nrst)
		(customLow_ff & ~MASK_CUSTOM_LOW) == 8'h00 && (powerCtl_ff & ~MASK_POWER) == 8'h00
		&& (slowRate_ff & ~MASK_SLOW_RATE) == 8'h00 && (clkDiv_ff & ~MASK_CLK_DIV) == 8'h00)
		else $error("reserved bit stored");

	first_wait_a: assert property (@(posedge clk) disable iff (!nrst)
		(avs_read || avs_write) && !$past(avs_read || avs_write) |-> avs_waitrequest)
		else $error("new request not held for one wait state");

	read_misalign_a: assert property (@(posedge clk) disable iff (!nrst)
		avs_read && !ack_ff && !idxOk |=> avs_readdata == 32'h0000_0000)
		else $error("misaligned read not zero");

	write_ignored_a: assert property (@(posedge clk) disable iff (!nrst)
		avs_write && ack_ff && !avs_byteenable[0] |=> $stable(swing_ff) && $stable(powerCtl_ff))
		else $error("write with lane 0 disabled changed a register");

	chan_a_on_a: assert property (@(posedge clk) disable iff (!nrst)
		!powerCtl_ff[POS_CHAN_A_OFF] |=> !power.chanAOff)
		else $error("channel A not returned to normal");

	standby_clear_a: assert property (@(posedge clk) disable iff (!nrst)
		!powerCtl_ff[POS_STANDBY] && !sleepSync |=> !power.standby)
		else $error("standby without cause");

	global_clear_a: assert property (@(posedge clk) disable iff (!nrst)
		!powerCtl_ff[POS_FULL_OFF] && !sleepSync |=> !power.fullChipOff)
		else $error("global power-down without cause");

	legal_flag_a: assert property (@(posedge clk) disable iff (!nrst)
		swing_ff == SWING_MORE_100 |=> swingCodeLegal)
		else $error("listed swing code flagged illegal");

	div_one_a: assert property (@(posedge clk) disable iff (!nrst)
		(clkDivSelect == DIV_BY1A || clkDivSelect == DIV_BY1B) |-> sampleEn)
		else $error("divide by one missed a cycle");

endmodule : acb_config_bank

// [logic/acb_pkg.sv]
// constants, field layouts and carrier types of the converter configuration bank
package acb_pkg;

	// =====================================================================
	// register indexes, byte address is four times the index
	localparam logic [7:0] IDX_CUSTOM_HIGH = 8'h0e;
	localparam logic [7:0] IDX_CUSTOM_LOW  = 8'h0f;
	localparam logic [7:0] IDX_SLOW_RATE   = 8'h13;
	localparam logic [7:0] IDX_POWER       = 8'h15;
	localparam logic [7:0] IDX_SWING       = 8'h25;
	localparam logic [7:0] IDX_CLK_DIV     = 8'h27;
	localparam int         ADDR_W          = 10;
	localparam int         ADDR_LSB        = 2;

	// =====================================================================
	// writable bits of each register, reserved bits are not stored
	localparam logic [7:0] MASK_CUSTOM_HIGH = 8'hff;
	localparam logic [7:0] MASK_CUSTOM_LOW  = 8'hfc;
	localparam logic [7:0] MASK_SLOW_RATE   = 8'h03;
	localparam logic [7:0] MASK_POWER       = 8'h6d;
	localparam logic [7:0] MASK_SWING       = 8'hff;
	localparam logic [7:0] MASK_CLK_DIV     = 8'hc0;
	localparam logic [7:0] REG_RESET        = 8'h00;

	// =====================================================================
	// field positions
	localparam int POS_CUSTOM_LOW   = 2;
	localparam int POS_CHAN_A_OFF   = 6;
	localparam int POS_CHAN_B_OFF   = 5;
	localparam int POS_STANDBY      = 3;
	localparam int POS_FULL_OFF     = 2;
	localparam int POS_SLEEP_ROLE   = 0;
	localparam int POS_CLK_DIV      = 6;
	localparam int WORD_W           = 14;
	localparam int CHANNELS         = 2;

	// =====================================================================
	// codes
	localparam logic [3:0] PATTERN_CUSTOM = 4'h5;
	localparam logic [1:0] DIV_BY1A       = 2'h0;
	localparam logic [1:0] DIV_BY1B       = 2'h1;
	localparam logic [1:0] DIV_BY2        = 2'h2;
	localparam logic [1:0] DIV_BY4        = 2'h3;
	localparam logic [1:0] DIV_CNT_1      = 2'h0;
	localparam logic [1:0] DIV_CNT_2      = 2'h1;
	localparam logic [1:0] DIV_CNT_4      = 2'h3;
	localparam logic [7:0] SWING_DEFAULT  = 8'h00;
	localparam logic [7:0] SWING_LESS_50  = 8'hd9;
	localparam logic [7:0] SWING_LESS_100 = 8'hea;
	localparam logic [7:0] SWING_LESS_300 = 8'hfd;
	localparam logic [7:0] SWING_MORE_100 = 8'hce;

	// =====================================================================
	// carriers
	typedef struct packed {
		logic chanAOff;
		logic chanBOff;
		logic standby;
		logic fullChipOff;
	} acb_power_t;

	typedef struct packed {
		logic [ADDR_W-1:0] address;
		logic              read;
		logic              write;
		logic [3:0]        byteenable;
		logic [31:0]       writedata;
	} acb_avs_req_t;

endpackage : acb_pkg

// [logic/acb_sync2.sv]
// two flip-flop synchroniser for pin levels
`timescale 1ns/10ps
module acb_sync2 #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk,
	input  wire logic             nrst,
	input  wire logic [WIDTH-1:0] asyncIn,
	output logic      [WIDTH-1:0] syncOut
);

	logic [WIDTH-1:0] meta_ff;

	// =====================================================================
	// first stage is read only by the second
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			meta_ff <= '0;
			syncOut <= '0;
		end else begin
			meta_ff <= asyncIn;
			syncOut <= meta_ff;
		end
	end

endmodule : acb_sync2

// [sim/tb_top.sv]
// self-checking testbench of the converter configuration bank
`timescale 1ns/10ps
module tb_top
	import acb_pkg::*;
();
	// =====================================================================
	// design signals
	logic                            clk;
	logic                            nrst;
	logic [ADDR_W-1:0]               avs_address;
	logic                            avs_read;
	logic                            avs_write;
	logic [3:0]                      avs_byteenable;
	logic [31:0]                     avs_writedata;
	logic [31:0]                     avs_readdata;
	logic                            avs_waitrequest;
	logic                            sleepPin;
	logic [CHANNELS-1:0][3:0]        chanPatternSelect;
	logic [CHANNELS-1:0][WORD_W-1:0] chanSample;
	logic [CHANNELS-1:0][WORD_W-1:0] chanData;
	acb_power_t                      power;
	logic [1:0]                      slowRateSelect;
	logic [7:0]                      swingCode;
	logic                            swingCodeLegal;
	logic [1:0]                      clkDivSelect;
	logic                            sampleEn;
	int                              mismatches;
	int                              checks_done;
	logic [31:0]                     rd;
	int                              pulses;
	logic [7:0] idxs   [6] = '{IDX_CUSTOM_HIGH, IDX_CUSTOM_LOW, IDX_SLOW_RATE,
		IDX_POWER, IDX_SWING, IDX_CLK_DIV};
	logic [7:0] vals   [6] = '{8'ha5, 8'h9c, 8'h02, 8'h6d, 8'hd9, 8'hc0};
	logic [7:0] swings [5] = '{SWING_DEFAULT, SWING_LESS_50, SWING_LESS_100,
		SWING_LESS_300, SWING_MORE_100};
	logic [7:0] pwrIn  [4] = '{8'h40, 8'h20, 8'h08, 8'h04};
	logic [3:0] pwrOut [4] = '{4'h8, 4'h4, 4'h2, 4'h1};
	int         divCnt [4] = '{8, 8, 4, 2};

	acb_config_bank u_dut (
		.clk               (clk),
		.nrst              (nrst),
		.avs_address       (avs_address),
		.avs_read          (avs_read),
		.avs_write         (avs_write),
		.avs_byteenable    (avs_byteenable),
		.avs_writedata     (avs_writedata),
		.avs_readdata      (avs_readdata),
		.avs_waitrequest   (avs_waitrequest),
		.sleepPin          (sleepPin),
		.chanPatternSelect (chanPatternSelect),
		.chanSample        (chanSample),
		.chanData          (chanData),
		.power             (power),
		.slowRateSelect    (slowRateSelect),
		.swingCode         (swingCode),
		.swingCodeLegal    (swingCodeLegal),
		.clkDivSelect      (clkDivSelect),
		.sampleEn          (sampleEn)
	);

	always #2.5 clk = ~clk;

	// =====================================================================
	// reporting
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : end_of_test

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// =====================================================================
	// avalon access: one edge passes first so a release is never overwritten
	task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
		int n;
		n = 0;
		@(posedge clk);
		avs_address   <= {idx, 2'b00};
		avs_write     <= wr;
		avs_read      <= !wr;
		avs_writedata <= {24'h0, wd};
		do begin
			@(posedge clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 50);
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read  <= 1'b0;
		if (n >= 50) begin
			mismatches++;
			$display("wrong value waitrequest expected 0 seen %b", avs_waitrequest);
			end_of_test();
		end
	endtask : bus

	task automatic rdchk(input string nm, input logic [7:0] idx, input logic [7:0] e);
		bus(1'b0, idx, 8'h00);
		chk(nm, {24'h0, e}, rd);
	endtask : rdchk

	task automatic wait_edges(input int n);
		repeat (n) @(posedge clk);
	endtask : wait_edges

	// =====================================================================
	// main sequence
	initial begin
		clk               = 1'b0;
		nrst              = 1'b0;
		avs_address       = '0;
		avs_read          = 1'b0;
		avs_write         = 1'b0;
		avs_byteenable    = 4'hf;
		avs_writedata     = '0;
		sleepPin          = 1'b0;
		chanPatternSelect = '0;
		chanSample        = '0;
		mismatches        = 0;
		checks_done       = 0;
		wait_edges(16);
		nrst <= 1'b1;
		for (int i = 0; i < 6; i++) rdchk("reset value", idxs[i], 8'h00);
		for (int i = 0; i < 6; i++) bus(1'b1, idxs[i], vals[i]);
		for (int i = 0; i < 6; i++) rdchk("readback", idxs[i], vals[i]);
		rdchk("unmapped read", 8'h10, 8'h00);
		chk("slow rate", 32'(2'h2), 32'(slowRateSelect));
		// custom word on channel A, samples on channel B
		chanPatternSelect[0] <= PATTERN_CUSTOM;
		chanPatternSelect[1] <= 4'h0;
		chanSample[0]        <= 14'h0bad;
		chanSample[1]        <= 14'h1234;
		wait_edges(2);
		chk("custom word A", 32'({vals[0], vals[1][7:2]}), 32'(chanData[0]));
		chk("sample B", 32'(14'h1234), 32'(chanData[1]));
		chanPatternSelect[1] <= PATTERN_CUSTOM;
		bus(1'b1, IDX_CUSTOM_LOW, 8'hfc);
		wait_edges(2);
		chk("custom word B", 32'({vals[0], 6'h3f}), 32'(chanData[1]));
		// power fields one by one
		for (int i = 0; i < 4; i++) begin
			bus(1'b1, IDX_POWER, pwrIn[i]);
			wait_edges(2);
			chk("power", 32'(pwrOut[i]), 32'(power));
		end
		// sleep pin in both roles
		bus(1'b1, IDX_POWER, 8'h00);
		sleepPin <= 1'b1;
		wait_edges(5);
		chk("sleep global", 32'(4'h1), 32'(power));
		bus(1'b1, IDX_POWER, 8'h01);
		wait_edges(5);
		chk("sleep standby", 32'(4'h2), 32'(power));
		sleepPin <= 1'b0;
		wait_edges(5);
		chk("sleep released", 32'(4'h0), 32'(power));
		// swing codes
		for (int i = 0; i < 5; i++) begin
			bus(1'b1, IDX_SWING, swings[i]);
			wait_edges(2);
			chk("swing", 32'(swings[i]), 32'(swingCode));
			chk("swing legal", 32'(1'b1), 32'(swingCodeLegal));
		end
		// write with lane 0 disabled is ignored
		avs_byteenable <= 4'he;
		bus(1'b1, IDX_SWING, 8'hd9);
		avs_byteenable <= 4'hf;
		rdchk("masked write", IDX_SWING, SWING_MORE_100);
		// sampling clock divider
		for (int s = 0; s < 4; s++) begin
			bus(1'b1, IDX_CLK_DIV, {2'(s), 6'h00});
			wait_edges(6);
			chk("div select", 32'(s), 32'(clkDivSelect));
			pulses = 0;
			for (int c = 0; c < 8; c++) begin
				@(posedge clk);
				if (sampleEn === 1'b1) pulses++;
			end
			chk("sample pulses", 32'(divCnt[s]), 32'(pulses));
		end
		// second reset clears every field
		@(posedge clk);
		nrst <= 1'b0;
		wait_edges(3);
		nrst <= 1'b1;
		for (int i = 0; i < 6; i++) rdchk("second reset", idxs[i], 8'h00);
		end_of_test();
	end
endmodule : tb_top
